// file: rtl/reset_strap_defines.vh
// Constants for the reset and strap selection block
`ifndef RESET_STRAP_DEFINES_VH
`define RESET_STRAP_DEFINES_VH
`define SYNC_STAGES 2
`define RST_STRETCH_W 4
`define RST_STRETCH_CYCLES 4'h8
`define BOOT_FLASH 1'b1
`define BOOT_ROM 1'b0
`define DBG_EMULATION 1'b1
`define DBG_BOUNDARY 1'b0
`endif

// file: rtl/sync_2ff.v
// Two-flop synchroniser for one level from outside the clock domain
module sync_2ff (
  input wire clk_sys, // System clock
  input wire rst,     // Asynchronous reset, active high
  input wire init,    // Value during reset is fixed by parameter
  input wire d,       // Asynchronous input
  output wire q       // Synchronised output
);
  parameter RESET_VALUE = 1'b0;
  reg meta_reg;
  reg sync_reg;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_reg <= RESET_VALUE;
      sync_reg <= RESET_VALUE;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end
  assign q = sync_reg ^ (init & 1'b0);
endmodule // sync_2ff

// file: rtl/reset_strap_debug_select.v
// Power-on reset, system reset, boot and debug strap capture, returned test clock
`include "reset_strap_defines.vh"
module reset_strap_debug_select (
  input wire clk_sys,                 // System clock, 200 MHz
  input wire rst,                     // Asynchronous reset, active high
  input wire power_on_reset_n_in,     // Power-on reset pin level
  output reg power_on_reset_n_out,    // Power-on reset pin drive value
  output reg power_on_reset_n_oe_n,   // Power-on reset drive enable, low drives
  input wire system_reset_n_in,       // System reset pin level
  output reg system_reset_n_out,      // System reset pin drive value
  output reg system_reset_n_oe_n,     // System reset drive enable, low drives
  input wire debug_function_strap_in, // Debug strap pin level
  output reg debug_function_strap_out,  // Returned test clock drive value
  output reg debug_function_strap_oe_n, // Debug pin drive enable, low drives
  input wire test_clock,              // Test clock from the probe
  input wire test_reset_n,            // Test reset pin, active low
  input wire boot_source_strap,       // Boot strap pin
  output reg chip_reset_reg,          // Whole-chip logic reset, active high
  output reg cpu_reset_reg,           // Processor reset, active high
  output reg tap_reset_reg,           // Test port reset, active high
  output reg boot_from_flash_reg,     // High boots flash, low boots ROM
  output reg emulation_mode_reg,      // High routes test port to processor
  output reg tck_sync_reg             // Synchronised test clock for the core
);
  parameter STRETCH_CYCLES = `RST_STRETCH_CYCLES;

  wire por_n_sync;
  wire sysrst_n_sync;
  wire dbg_sync;
  wire boot_sync;
  wire tck_sync;
  wire trst_n_sync;
  reg por_n_d_reg;
  reg [`RST_STRETCH_W-1:0] stretch_reg;
  reg [`RST_STRETCH_W-1:0] stretch_next;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  sync_2ff #(.RESET_VALUE(1'b0)) u_por (.clk_sys(clk_sys), .rst(rst), .init(1'b0),
    .d(power_on_reset_n_in), .q(por_n_sync));
  sync_2ff #(.RESET_VALUE(1'b1)) u_sys (.clk_sys(clk_sys), .rst(rst), .init(1'b0),
    .d(system_reset_n_in), .q(sysrst_n_sync));
  sync_2ff #(.RESET_VALUE(1'b1)) u_dbg (.clk_sys(clk_sys), .rst(rst), .init(1'b0),
    .d(debug_function_strap_in), .q(dbg_sync));
  sync_2ff #(.RESET_VALUE(1'b1)) u_boot (.clk_sys(clk_sys), .rst(rst), .init(1'b0),
    .d(boot_source_strap), .q(boot_sync));
  sync_2ff #(.RESET_VALUE(1'b0)) u_tck (.clk_sys(clk_sys), .rst(rst), .init(1'b0),
    .d(test_clock), .q(tck_sync));
  sync_2ff #(.RESET_VALUE(1'b0)) u_trst (.clk_sys(clk_sys), .rst(rst), .init(1'b0),
    .d(test_reset_n), .q(trst_n_sync));

  ////////////////////////////////////////////////////////////////////////
  // Own reset stretch: pulls power-on reset low after local reset
  always @* begin
    stretch_next = stretch_reg;
    if (stretch_reg != {`RST_STRETCH_W{1'b0}}) begin
      stretch_next = stretch_reg - {{(`RST_STRETCH_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stretch_reg <= STRETCH_CYCLES;
      por_n_d_reg <= 1'b0;
      power_on_reset_n_out <= 1'b0;
      power_on_reset_n_oe_n <= 1'b0;
      system_reset_n_out <= 1'b0;
      system_reset_n_oe_n <= 1'b0;
      debug_function_strap_out <= 1'b0;
      debug_function_strap_oe_n <= 1'b1;
      chip_reset_reg <= 1'b1;
      cpu_reset_reg <= 1'b1;
      tap_reset_reg <= 1'b1;
      boot_from_flash_reg <= `BOOT_FLASH;
      emulation_mode_reg <= `DBG_EMULATION;
      tck_sync_reg <= 1'b0;
    end else begin
      stretch_reg <= stretch_next;
      por_n_d_reg <= por_n_sync;
      // Open drain: drive low only, pull-up releases
      power_on_reset_n_out <= 1'b0;
      power_on_reset_n_oe_n <= (stretch_next == {`RST_STRETCH_W{1'b0}});
      chip_reset_reg <= ~por_n_sync;
      system_reset_n_out <= 1'b0;
      system_reset_n_oe_n <= por_n_sync;
      cpu_reset_reg <= ~por_n_sync | ~sysrst_n_sync;
      tap_reset_reg <= ~trst_n_sync | ~por_n_sync;
      // Straps captured on synchronised rising edge of power-on reset
      if (por_n_sync & ~por_n_d_reg) begin
        emulation_mode_reg <= dbg_sync;
        boot_from_flash_reg <= boot_sync;
      end
      tck_sync_reg <= tck_sync;
      if (~por_n_sync) begin
        debug_function_strap_oe_n <= 1'b1;
        debug_function_strap_out <= 1'b0;
      end else if (por_n_d_reg & (emulation_mode_reg == `DBG_EMULATION)) begin
        debug_function_strap_oe_n <= 1'b0;
        debug_function_strap_out <= tck_sync;
      end else begin
        debug_function_strap_oe_n <= 1'b1;
        debug_function_strap_out <= 1'b0;
      end
    end
  end
endmodule // reset_strap_debug_select

// file: test/rsds_assertions.sv
// Port checker for the reset and strap block
module rsds_chk(input wire clk_sys, rst, power_on_reset_n_in, system_reset_n_in,
  system_reset_n_oe_n, test_reset_n, debug_function_strap_out, debug_function_strap_oe_n,
  chip_reset_reg, cpu_reset_reg, tap_reset_reg, boot_from_flash_reg, emulation_mode_reg,
  tck_sync_reg);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence ran2; !chip_reset_reg ##1 !chip_reset_reg; endsequence
  chip_rst_a: assert property (!power_on_reset_n_in |-> ##[1:4] chip_reset_reg)
    else $error("chip reset late");
  sys_drive_a: assert property (!power_on_reset_n_in |-> ##[1:4] !system_reset_n_oe_n)
    else $error("system reset not driven");
  cpu_rst_a: assert property (!system_reset_n_in |-> ##[1:4] cpu_reset_reg)
    else $error("cpu reset late");
  cpu_only_a: assert property (power_on_reset_n_in [*5] |-> !chip_reset_reg)
    else $error("chip reset without power-on reset");
  strap_keep_a:
    assert property (ran2 |-> $stable({emulation_mode_reg, boot_from_flash_reg}))
    else $error("strap changed after capture");
  dbg_dir_a:
    assert property (ran2 |-> debug_function_strap_oe_n == !emulation_mode_reg)
    else $error("debug pin direction wrong");
  returned_test_clock_copy_a:
    assert property (!debug_function_strap_oe_n |-> debug_function_strap_out == tck_sync_reg)
    else $error("returned clock differs");
  tap_rst_a: assert property (!test_reset_n |-> ##[1:4] tap_reset_reg)
    else $error("test reset late");
endmodule // rsds_chk
bind reset_strap_debug_select rsds_chk u_rsds_chk(.*);

// file: test/board_model.sv
// Host board reset circuitry and debug probe
module board_model(input wire logic por_hold_n, sys_hold_n, dbg_strap, tck_en,
  power_on_reset_n_out, power_on_reset_n_oe_n, system_reset_n_out, system_reset_n_oe_n,
  debug_function_strap_out, debug_function_strap_oe_n,
  output logic power_on_reset_n_in, system_reset_n_in, debug_function_strap_in, test_clock);
  timeunit 1ns;
  timeprecision 1ps;
  // Open drain reset lines with pull-ups; debug line reads the strap unless driven
  assign power_on_reset_n_in = por_hold_n & (power_on_reset_n_oe_n | power_on_reset_n_out);
  assign system_reset_n_in = sys_hold_n & (system_reset_n_oe_n | system_reset_n_out);
  assign debug_function_strap_in = debug_function_strap_oe_n ? dbg_strap : debug_function_strap_out;
  // Probe clock stands low outside sessions
  initial begin
    test_clock = 0;
    forever #62.5 test_clock = tck_en & ~test_clock;
  end
endmodule // board_model

// file: test/tb.sv
// Self-checking bench for the reset and strap block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst = 1, por_hold_n = 0, sys_hold_n = 1, dbg_strap = 1, tck_en = 0;
  logic test_reset_n = 1, boot_source_strap = 1;
  logic [31:0] lfsr = 32'h21f1;
  wire power_on_reset_n_in, power_on_reset_n_out, power_on_reset_n_oe_n, system_reset_n_in;
  wire system_reset_n_out, system_reset_n_oe_n, debug_function_strap_in, test_clock;
  wire debug_function_strap_out, debug_function_strap_oe_n, chip_reset_reg, cpu_reset_reg;
  wire tap_reset_reg, boot_from_flash_reg, emulation_mode_reg, tck_sync_reg;
  int num_errors = 0, n_tests = 0, cyc = 0, i, w;
  reset_strap_debug_select u_reset_strap_debug_select(.*);
  board_model u_board_model(.*);
  always #2.5 clk_sys = ~clk_sys;
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], ^(v & 32'h80200003)};
  endfunction
  task automatic chk(input logic got, input int exp);
    n_tests++;
    if (got !== exp[0]) begin
      num_errors++;
      $display("[FAIL] %0t got %b exp %0d", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("errors %0d tests %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) if (++cyc == 20000) begin
    num_errors++;
    results;
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    rst = 0;
    for (i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      w = 12 + lfsr[2:0];
      por_hold_n = 0;
      dbg_strap = i[0];
      boot_source_strap = i[1];
      repeat (w) @(negedge clk_sys);
      chk(cpu_reset_reg, 1);
      chk(system_reset_n_in, 0);
      chk(chip_reset_reg, 1);
      chk(power_on_reset_n_oe_n, 1);
      por_hold_n = 1;
      repeat (w) @(negedge clk_sys);
      dbg_strap = ~i[0];
      boot_source_strap = ~i[1];
      repeat (4) @(negedge clk_sys);
      chk(emulation_mode_reg, i[0]);
      chk(boot_from_flash_reg, i[1]);
      chk(debug_function_strap_oe_n, !i[0]);
      if (i[0]) begin
        tck_en = 1;
        repeat (3) begin
          @(posedge test_clock);
          repeat (6) @(negedge clk_sys);
          chk(debug_function_strap_in, test_clock);
          chk(tck_sync_reg, test_clock);
        end
        tck_en = 0;
      end
      sys_hold_n = 0;
      test_reset_n = lfsr[3];
      repeat (5) @(negedge clk_sys);
      chk(chip_reset_reg, 0);
      chk(cpu_reset_reg, 1);
      chk(tap_reset_reg, !lfsr[3]);
      sys_hold_n = 1;
      test_reset_n = 1;
    end
    results;
  end
endmodule // tb
